// *** design/vf_drive_defs.svh ***
// constants for the variable-frequency induction motor drive
// assumes a 20 MHz system clock; included by the drive only
`ifndef VF_DRIVE_DEFS_SVH
`define VF_DRIVE_DEFS_SVH

// ----------------------------------------------------------------------
// clock and time base
// ----------------------------------------------------------------------
`define CLK_HZ 64'd20000000
`define CLK_MHZ 32'd20
`define TICK_US 32'd62500
`define TICKS_PER_SEC 4'hf
`define PWM_SLOW_CHZ 64'd975000
`define PWM_FAST_CHZ 64'd1953000
`define CHZ_PER_HZ 64'd100

// ----------------------------------------------------------------------
// value limits and reset defaults
// ----------------------------------------------------------------------
`define MOD_MAX 8'hc8
`define FREQ_MAX 8'h7f
`define KICK_FREQ_LIMIT 8'h80
`define ACCEL_DEFAULT 8'h0a
`define DECEL_DEFAULT 8'h05
`define CURVE_POINTS 17
`define CURVE_LAST 5'h10
`define CURVE_STEP_DEFAULT 8'h0c
`define PARAM_SLOTS 16
`define STATUS_OK 8'h00
`define STATUS_BAD 8'hff
`define PHASE_INC_PER_HZ 32'hd7

`endif

// *** design/vf_drive_pkg.sv ***
// types used by the drive; the bench and checker use raw codes
// assumes vf_drive_defs.svh is on the include path
package vf_drive_pkg;

  // ----------------------------------------------------------------------
  // drive sequencing states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DRV_STOPPED = 2'b00,
    DRV_KICK = 2'b01,
    DRV_RUN = 2'b10
  } drive_state_t;

  // ----------------------------------------------------------------------
  // setting selected by a configuration write
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    SEL_ACCEL = 4'h0,
    SEL_DECEL = 4'h1,
    SEL_KICK_FREQ = 4'h2,
    SEL_KICK_START = 4'h3,
    SEL_KICK_END = 4'h4,
    SEL_KICK_DUR = 4'h5,
    SEL_FREQ = 4'h6,
    SEL_CURVE = 4'h7,
    SEL_LINE = 4'h8,
    SEL_MOTOR = 4'h9,
    SEL_PARAM = 4'ha,
    SEL_KICK_ON = 4'hb,
    SEL_KICK_OFF = 4'hc
  } cfg_sel_t;

endpackage

// *** design/pwm_channel.sv ***
// one edge-aligned pwm output with a double-buffered duty value
// assumes a shared period counter and a wrap pulse from the parent
`timescale 1ns/100ps
`default_nettype none

module pwm_channel (
  input wire logic clk_sys, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic wrap, // pulse in the last clock of each period
  input wire logic [11:0] count, // shared period counter
  input wire logic [11:0] duty, // requested high time in clocks
  output logic pwm_out // registered pwm output
);

  logic [11:0] duty_r;
  logic [11:0] duty_nxt;
  logic pwm_out_nxt;

  // take the new duty only at a period boundary to avoid glitches
  always_comb begin
    duty_nxt = wrap ? duty : duty_r;
    pwm_out_nxt = (count < duty_r);
  end

  // register duty and output
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      duty_r <= 12'h000;
      pwm_out <= 1'b0;
    end else begin
      duty_r <= duty_nxt;
      pwm_out <= pwm_out_nxt;
    end
  end

endmodule // pwm_channel

`default_nettype wire

// *** design/vf_induction_motor_drive.sv ***
// open-loop v/f drive for a single-phase induction motor
// assumes synchronous control inputs, one write per strobe, 20 MHz clock
`timescale 1ns/100ps
`default_nettype none
`include "vf_drive_defs.svh"

module vf_induction_motor_drive #(
  parameter int unsigned TICK_CYCLES = `TICK_US * `CLK_MHZ // 62.5 ms
) (
  input wire logic clk_sys, // system clock, 20 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic switch_rate_select, // 0 slow, 1 fast switching
  input wire logic cfg_wr, // one-cycle write strobe
  input wire logic [3:0] cfg_sel, // which setting is written
  input wire logic [4:0] cfg_index, // curve point or parameter slot
  input wire logic [7:0] cfg_data, // value written
  input wire logic flag_clear_request, // pulse clears tick flag
  input wire logic [3:0] param_rd_index, // parameter slot to read
  output logic [7:0] param_rd_value, // registered slot value
  output logic [7:0] cmd_status, // kick frequency write status
  output logic tick_flag, // sticky 1/16 s flag
  output logic [7:0] actual_freq, // present output frequency, Hz
  output logic [7:0] modulation, // present output modulation, %
  output logic running, // drive not stopped
  output logic kick_active, // kick phase in progress
  output logic drive_output_a, // pwm toward bridge leg a
  output logic drive_output_b // pwm toward bridge leg b
);

  // ----------------------------------------------------------------------
  // time base constants
  // ----------------------------------------------------------------------
  localparam logic [11:0] PER_SLOW =
    12'(`CLK_HZ * `CHZ_PER_HZ / `PWM_SLOW_CHZ);
  localparam logic [11:0] PER_FAST =
    12'(`CLK_HZ * `CHZ_PER_HZ / `PWM_FAST_CHZ);
  localparam logic [20:0] TICK_LAST = 21'(TICK_CYCLES - 1);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [7:0] accel_r, accel_nxt, decel_r, decel_nxt;
  logic [7:0] kick_freq_r, kick_freq_nxt;
  logic [7:0] kick_start_modulation_r, kick_start_modulation_nxt;
  logic [7:0] kick_end_modulation_r, kick_end_modulation_nxt;
  logic [7:0] kick_duration_r, kick_duration_nxt;
  logic kick_en_r, kick_en_nxt;
  logic [7:0] target_r, target_nxt;
  logic [7:0] line_voltage_value_r, line_voltage_value_nxt;
  logic [7:0] motor_rating_value_r, motor_rating_value_nxt;
  logic [7:0] status_r, status_nxt;
  logic [7:0] curve_r [`CURVE_POINTS];
  logic [7:0] curve_nxt [`CURVE_POINTS];
  logic [7:0] param_r [`PARAM_SLOTS];
  logic [7:0] param_nxt [`PARAM_SLOTS];
  logic [7:0] param_rd_nxt;
  vf_drive_pkg::drive_state_t state_r, state_nxt;
  logic [7:0] freq_r, freq_nxt;
  logic [11:0] kick_ticks_r, kick_ticks_nxt;
  logic [20:0] tick_cnt_r, tick_cnt_nxt;
  logic [3:0] sub_sec_r, sub_sec_nxt;
  logic tick_flag_r, tick_flag_nxt;
  logic [11:0] pwm_cnt_r, pwm_cnt_nxt;
  logic [31:0] phase_r, phase_nxt;
  logic [7:0] mod_r, mod_nxt;
  logic [11:0] duty_a_r, duty_a_nxt, duty_b_r, duty_b_nxt;
  logic tick_pulse, sec_pulse, pwm_wrap;
  logic [11:0] period;
  logic [7:0] cv;

  // clip a percentage to the modulation ceiling
  function automatic logic [7:0] clip_mod(input logic [7:0] v);
    clip_mod = (v > `MOD_MAX) ? `MOD_MAX : v;
  endfunction

  // ----------------------------------------------------------------------
  // configuration writes
  // ----------------------------------------------------------------------
  vf_drive_pkg::cfg_sel_t sel;
  assign sel = vf_drive_pkg::cfg_sel_t'(cfg_sel);
  assign cv = cfg_data;

  // decode one write; stopping is handled by the sequencer below
  always_comb begin
    accel_nxt = accel_r;
    decel_nxt = decel_r;
    kick_freq_nxt = kick_freq_r;
    kick_start_modulation_nxt = kick_start_modulation_r;
    kick_end_modulation_nxt = kick_end_modulation_r;
    kick_duration_nxt = kick_duration_r;
    kick_en_nxt = kick_en_r;
    target_nxt = target_r;
    line_voltage_value_nxt = line_voltage_value_r;
    motor_rating_value_nxt = motor_rating_value_r;
    status_nxt = status_r;
    curve_nxt = curve_r;
    param_nxt = param_r;
    param_rd_nxt = param_r[param_rd_index];
    if (cfg_wr) begin
      if (sel == vf_drive_pkg::SEL_ACCEL) begin
        accel_nxt = cv;
      end else if (sel == vf_drive_pkg::SEL_DECEL) begin
        decel_nxt = cv;
      end else if (sel == vf_drive_pkg::SEL_KICK_FREQ) begin
        if (cv < `KICK_FREQ_LIMIT) begin
          kick_freq_nxt = cv;
          status_nxt = `STATUS_OK;
        end else begin
          status_nxt = `STATUS_BAD;
        end
      end else if (sel == vf_drive_pkg::SEL_KICK_START) begin
        kick_start_modulation_nxt = clip_mod(cv);
      end else if (sel == vf_drive_pkg::SEL_KICK_END) begin
        kick_end_modulation_nxt = clip_mod(cv);
      end else if (sel == vf_drive_pkg::SEL_KICK_DUR) begin
        kick_duration_nxt = cv;
      end else if (sel == vf_drive_pkg::SEL_FREQ) begin
        target_nxt = (cv > `FREQ_MAX) ? `FREQ_MAX : cv;
      end else if (sel == vf_drive_pkg::SEL_CURVE) begin
        if (cfg_index <= `CURVE_LAST) begin
          curve_nxt[cfg_index] = clip_mod(cv);
        end
      end else if (sel == vf_drive_pkg::SEL_LINE) begin
        line_voltage_value_nxt = cv;
      end else if (sel == vf_drive_pkg::SEL_MOTOR) begin
        motor_rating_value_nxt = cv;
      end else if (sel == vf_drive_pkg::SEL_PARAM) begin
        param_nxt[cfg_index[3:0]] = cv;
      end else if (sel == vf_drive_pkg::SEL_KICK_ON) begin
        kick_en_nxt = 1'b1;
      end else if (sel == vf_drive_pkg::SEL_KICK_OFF) begin
        kick_en_nxt = 1'b0;
      end
    end
  end

  // register the settings; curve defaults to a straight line
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      accel_r <= `ACCEL_DEFAULT;
      decel_r <= `DECEL_DEFAULT;
      kick_freq_r <= 8'h00;
      kick_start_modulation_r <= 8'h00;
      kick_end_modulation_r <= 8'h00;
      kick_duration_r <= 8'h00;
      kick_en_r <= 1'b0;
      target_r <= 8'h00;
      line_voltage_value_r <= 8'h00;
      motor_rating_value_r <= 8'h00;
      status_r <= `STATUS_OK;
      param_rd_value <= 8'h00;
      for (int i = 0; i < `CURVE_POINTS; i++) begin
        curve_r[i] <= 8'(i) * `CURVE_STEP_DEFAULT;
      end
      for (int i = 0; i < `PARAM_SLOTS; i++) begin
        param_r[i] <= 8'h00;
      end
    end else begin
      accel_r <= accel_nxt;
      decel_r <= decel_nxt;
      kick_freq_r <= kick_freq_nxt;
      kick_start_modulation_r <= kick_start_modulation_nxt;
      kick_end_modulation_r <= kick_end_modulation_nxt;
      kick_duration_r <= kick_duration_nxt;
      kick_en_r <= kick_en_nxt;
      target_r <= target_nxt;
      line_voltage_value_r <= line_voltage_value_nxt;
      motor_rating_value_r <= motor_rating_value_nxt;
      status_r <= status_nxt;
      param_rd_value <= param_rd_nxt;
      curve_r <= curve_nxt;
      param_r <= param_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // tick and one-second time base
  // ----------------------------------------------------------------------
  assign tick_pulse = (tick_cnt_r == TICK_LAST);
  assign sec_pulse = tick_pulse && (sub_sec_r == `TICKS_PER_SEC);

  // a tick in the same cycle as a clear keeps the flag set
  always_comb begin
    tick_cnt_nxt = tick_pulse ? 21'h000000 : tick_cnt_r + 21'h000001;
    sub_sec_nxt = tick_pulse ? sub_sec_r + 4'h1 : sub_sec_r;
    tick_flag_nxt = tick_flag_r;
    if (flag_clear_request) begin
      tick_flag_nxt = 1'b0;
    end
    if (tick_pulse) begin
      tick_flag_nxt = 1'b1;
    end
  end

  // register the time base
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tick_cnt_r <= 21'h000000;
      sub_sec_r <= 4'h0;
      tick_flag_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      sub_sec_r <= sub_sec_nxt;
      tick_flag_r <= tick_flag_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // start, kick and ramp sequencing
  // ----------------------------------------------------------------------
  logic [12:0] kick_len;
  assign kick_len = {1'b0, kick_duration_r, 4'h0};

  always_comb begin
    state_nxt = state_r;
    freq_nxt = freq_r;
    kick_ticks_nxt = kick_ticks_r;
    case (state_r)
      vf_drive_pkg::DRV_STOPPED: begin
        freq_nxt = 8'h00;
        if (target_r != 8'h00) begin
          kick_ticks_nxt = 12'h000;
          if (kick_en_r) begin
            state_nxt = vf_drive_pkg::DRV_KICK;
            freq_nxt = kick_freq_r;
          end else begin
            state_nxt = vf_drive_pkg::DRV_RUN;
          end
        end
      end
      vf_drive_pkg::DRV_KICK: begin
        if (target_r == 8'h00) begin
          state_nxt = vf_drive_pkg::DRV_STOPPED;
        end else if ({1'b0, kick_ticks_r} >= kick_len) begin
          state_nxt = vf_drive_pkg::DRV_RUN;
        end else if (tick_pulse) begin
          kick_ticks_nxt = kick_ticks_r + 12'h001;
        end
      end
      vf_drive_pkg::DRV_RUN: begin
        if (target_r == 8'h00) begin
          state_nxt = vf_drive_pkg::DRV_STOPPED;
        end else if (sec_pulse) begin
          if (freq_r < target_r) begin
            freq_nxt = (target_r - freq_r > accel_r) ?
              freq_r + accel_r : target_r;
          end else if (freq_r > target_r) begin
            freq_nxt = (freq_r - target_r > decel_r) ?
              freq_r - decel_r : target_r;
          end
        end
      end
      default: state_nxt = vf_drive_pkg::DRV_STOPPED;
    endcase
  end

  // register the sequencer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= vf_drive_pkg::DRV_STOPPED;
      freq_r <= 8'h00;
      kick_ticks_r <= 12'h000;
    end else begin
      state_r <= state_nxt;
      freq_r <= freq_nxt;
      kick_ticks_r <= kick_ticks_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // modulation: curve, kick ramp and voltage compensation
  // ----------------------------------------------------------------------
  logic [7:0] c_lo, c_hi, curve_mod, kick_mod, base_mod;
  logic [10:0] interp;
  logic [19:0] kick_prod;
  logic [15:0] comp;

  always_comb begin
    c_lo = curve_r[freq_r[6:3]];
    c_hi = curve_r[5'(freq_r[6:3]) + 5'h01];
    interp = 11'(c_lo * (4'h8 - {1'b0, freq_r[2:0]}))
      + 11'(c_hi * freq_r[2:0]);
    curve_mod = 8'(interp >> 3);
    kick_prod = 20'((kick_end_modulation_r - kick_start_modulation_r)
      * kick_ticks_r);
    kick_mod = (kick_len == 13'h0000) ? kick_end_modulation_r :
      kick_start_modulation_r + 8'(kick_prod / 20'(kick_len));
    base_mod = (state_r == vf_drive_pkg::DRV_KICK) ? kick_mod : curve_mod;
    // a zero line value would divide by zero, so pass through unscaled
    comp = (line_voltage_value_r == 8'h00) ? 16'(base_mod) :
      16'(base_mod * motor_rating_value_r) / 16'(line_voltage_value_r);
    mod_nxt = (comp > 16'(`MOD_MAX)) ? `MOD_MAX : comp[7:0];
  end

  // ----------------------------------------------------------------------
  // switching period, phase and duty computation
  // ----------------------------------------------------------------------
  assign period = switch_rate_select ? PER_FAST : PER_SLOW;
  assign pwm_wrap = (pwm_cnt_r >= period - 12'h001);

  logic [1:0] quad;
  logic [3:0] sidx;
  logic [7:0] sine;
  logic [15:0] amp;
  logic [10:0] half, off;

  always_comb begin
    pwm_cnt_nxt = pwm_wrap ? 12'h000 : pwm_cnt_r + 12'h001;
    phase_nxt = phase_r + freq_r * `PHASE_INC_PER_HZ;
    quad = phase_r[31:30];
    sidx = quad[0] ? ~phase_r[29:26] : phase_r[29:26];
    case (sidx)
      4'h0: sine = 8'h0d;
      4'h1: sine = 8'h25;
      4'h2: sine = 8'h3e;
      4'h3: sine = 8'h56;
      4'h4: sine = 8'h6d;
      4'h5: sine = 8'h83;
      4'h6: sine = 8'h98;
      4'h7: sine = 8'hab;
      4'h8: sine = 8'hbd;
      4'h9: sine = 8'hcd;
      4'ha: sine = 8'hdb;
      4'hb: sine = 8'he7;
      4'hc: sine = 8'hf0;
      4'hd: sine = 8'hf7;
      4'he: sine = 8'hfc;
      default: sine = 8'hff;
    endcase
    amp = sine * mod_r;
    half = period[11:1];
    off = 11'((27'(amp) * 27'(half)) >> 16);
    if (state_r == vf_drive_pkg::DRV_STOPPED) begin
      duty_a_nxt = 12'h000; // both legs low while stopped
      duty_b_nxt = 12'h000;
    end else if (quad[1]) begin
      duty_a_nxt = 12'(half - off);
      duty_b_nxt = 12'(half + off);
    end else begin
      duty_a_nxt = 12'(half + off);
      duty_b_nxt = 12'(half - off);
    end
  end

  // register modulation, phase and duty
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pwm_cnt_r <= 12'h000;
      phase_r <= 32'h00000000;
      mod_r <= 8'h00;
      duty_a_r <= 12'h000;
      duty_b_r <= 12'h000;
    end else begin
      pwm_cnt_r <= pwm_cnt_nxt;
      phase_r <= phase_nxt;
      mod_r <= mod_nxt;
      duty_a_r <= duty_a_nxt;
      duty_b_r <= duty_b_nxt;
    end
  end

  // the two bridge legs
  pwm_channel leg_a (
    .clk_sys(clk_sys),
    .rst(rst),
    .wrap(pwm_wrap),
    .count(pwm_cnt_r),
    .duty(duty_a_r),
    .pwm_out(drive_output_a)
  );

  pwm_channel leg_b (
    .clk_sys(clk_sys),
    .rst(rst),
    .wrap(pwm_wrap),
    .count(pwm_cnt_r),
    .duty(duty_b_r),
    .pwm_out(drive_output_b)
  );

  // ----------------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------------
  assign cmd_status = status_r;
  assign tick_flag = tick_flag_r;
  assign actual_freq = freq_r;
  assign modulation = mod_r;
  assign running = (state_r != vf_drive_pkg::DRV_STOPPED);
  assign kick_active = (state_r == vf_drive_pkg::DRV_KICK);

endmodule // vf_induction_motor_drive

`default_nettype wire

// *** verif/vf_drive_assertions.sv ***
// concurrent checks on the v/f drive's ports
// assumes it is bound to vf_induction_motor_drive
`timescale 1ns/100ps
`default_nettype none

module vf_drive_checks #(
  parameter int unsigned TICK_CYCLES = 100 // clocks per tick
) (
  input wire logic clk_sys, // clock
  input wire logic rst, // reset
  input wire logic cfg_wr, // write strobe
  input wire logic [3:0] cfg_sel, // setting code
  input wire logic [7:0] cfg_data, // value
  input wire logic flag_clear_request, // clear pulse
  input wire logic [7:0] cmd_status, // status
  input wire logic tick_flag, // tick flag
  input wire logic [7:0] actual_freq, // frequency
  input wire logic [7:0] modulation, // modulation
  input wire logic running, // running
  input wire logic kick_active, // kick phase
  input wire logic drive_output_a, // leg a
  input wire logic drive_output_b // leg b
);
  logic [31:0] ph_r, ph_nxt;
  logic seen_r, seen_nxt, ken_r, ken_nxt, tf_r, tf_nxt, rose, wrk, wrf;
  logic [7:0] kf_r, kf_nxt;
  logic [11:0] idle_r, idle_nxt;

  // ----------------------------------------------------------------------
  // helper state: tick phase, kick settings, time spent stopped
  // ----------------------------------------------------------------------
  assign rose = tick_flag & ~tf_r;
  assign wrk = cfg_wr && cfg_sel == 4'h2;
  assign wrf = cfg_wr && cfg_sel == 4'h6;
  always_comb begin
    tf_nxt = tick_flag;
    seen_nxt = seen_r | rose;
    ph_nxt = (ph_r == TICK_CYCLES - 1) ? 32'h0 : ph_r + 32'h1;
    if (rose) ph_nxt = 32'h1;
    ken_nxt = cfg_wr && cfg_sel == 4'hb ? 1'b1 : ken_r;
    if (cfg_wr && cfg_sel == 4'hc) ken_nxt = 1'b0;
    kf_nxt = wrk && cfg_data < 8'h80 ? cfg_data : kf_r;
    idle_nxt = running ? 12'h0 : idle_r + {11'h0, idle_r != 12'hfff};
    if (rst) begin
      {tf_nxt, seen_nxt, ken_nxt, ph_nxt, kf_nxt, idle_nxt} = '0;
    end
  end
  always_ff @(posedge clk_sys) begin
    {tf_r, seen_r, ken_r, ph_r, kf_r, idle_r} <=
      {tf_nxt, seen_nxt, ken_nxt, ph_nxt, kf_nxt, idle_nxt};
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_kick_refused: assert property (
    wrk && cfg_data >= 8'h80 |=> cmd_status == 8'hff)
    else $error("bad kick frequency not refused");
  chk_kick_taken: assert property (
    wrk && cfg_data < 8'h80 |=> cmd_status == 8'h00)
    else $error("good kick frequency not accepted");
  chk_status_holds: assert property (
    !wrk |=> $stable(cmd_status))
    else $error("status moved without a kick frequency write");
  chk_tick_period: assert property (
    rose && seen_r |-> ph_r == 32'h0)
    else $error("tick spacing wrong");
  chk_tick_cleared: assert property (
    flag_clear_request && seen_r && ph_r != TICK_CYCLES - 1 |=> !tick_flag)
    else $error("tick flag not cleared");
  chk_zero_stops: assert property (
    wrf && cfg_data == 8'h00 |-> ##3 (!running && actual_freq == 8'h00))
    else $error("zero command did not stop");
  chk_start_kick: assert property (
    wrf && cfg_data != 8'h00 && !running && ken_r
    |-> ##2 (running && kick_active && actual_freq == kf_r))
    else $error("start did not enter kick");
  chk_start_plain: assert property (
    wrf && cfg_data != 8'h00 && !running && !ken_r
    |-> ##2 (running && !kick_active && actual_freq == 8'h00))
    else $error("plain start wrong");
  chk_legs_idle: assert property (
    idle_r > 12'd2100 |-> !drive_output_a && !drive_output_b)
    else $error("pwm active while stopped");
  chk_mod_limit: assert property (
    modulation <= 8'hc8)
    else $error("modulation above limit");
  cover property (rose && seen_r);
  cover property ($rose(kick_active));
  cover property (wrk && cfg_data >= 8'h80);
endmodule // vf_drive_checks

bind vf_induction_motor_drive vf_drive_checks #(
  .TICK_CYCLES(TICK_CYCLES)
) checks (
  .clk_sys(clk_sys), .rst(rst), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel),
  .cfg_data(cfg_data), .flag_clear_request(flag_clear_request),
  .cmd_status(cmd_status), .tick_flag(tick_flag),
  .actual_freq(actual_freq), .modulation(modulation),
  .running(running), .kick_active(kick_active),
  .drive_output_a(drive_output_a), .drive_output_b(drive_output_b)
);
`default_nettype wire

// *** verif/power_stage_model.sv ***
// power stage model: times the switching period seen on both legs
// assumes the legs are the drive's registered pwm outputs
`timescale 1ns/100ps
`default_nettype none

module power_stage_model (
  input wire logic clk_sys, // clock
  input wire logic restart, // start a new measurement
  input wire logic leg_a, // bridge leg a
  input wire logic leg_b, // bridge leg b
  output logic [15:0] min_gap // shortest rising edge spacing
);
  logic [1:0] legs, prev_r, arm_r;
  logic [15:0] gap_r [2];
  assign legs = {leg_b, leg_a};
  // shortest rise spacing is one period; low duty only skips edges
  always_ff @(posedge clk_sys) begin
    prev_r <= legs;
    for (int k = 0; k < 2; k++) begin
      if (restart) begin
        gap_r[k] <= 16'h0;
        arm_r[k] <= 1'b0;
      end else if (legs[k] && !prev_r[k]) begin
        gap_r[k] <= 16'h0;
        arm_r[k] <= 1'b1;
        if (arm_r[k] && gap_r[k] + 16'h1 < min_gap) min_gap <= gap_r[k] + 16'h1;
      end else begin
        gap_r[k] <= gap_r[k] + 16'h1;
      end
    end
    if (restart) min_gap <= 16'hffff;
  end
endmodule // power_stage_model
`default_nettype wire

// *** verif/testbench.sv ***
// self-checking bench for the v/f drive
// assumes the checker binds itself and the stage model is compiled
`timescale 1ns/100ps
`default_nettype none

module testbench;
  localparam int unsigned TC = 100; // clocks per tick, 16 per second
  typedef struct {
    logic [3:0] sel;
    logic [4:0] idx;
    logic [7:0] data;
    logic [7:0] st;
    logic [7:0] prm;
  } row_t;
  logic clk_sys, rst, switch_rate_select, cfg_wr, flag_clear_request;
  logic [3:0] cfg_sel, param_rd_index;
  logic [4:0] cfg_index;
  logic [7:0] cfg_data, param_rd_value, cmd_status, actual_freq, modulation;
  logic tick_flag, running, kick_active, drive_output_a, drive_output_b;
  logic restart;
  logic [15:0] min_gap;
  int mismatches = 0;
  int tests_run = 0;
  int n;
  row_t rows [9] = '{'{4'ha, 5'h00, 8'h11, 8'h00, 8'h11},
    '{4'ha, 5'h0f, 8'h22, 8'h00, 8'h22}, '{4'h2, 5'h00, 8'h7f, 8'h00, 8'h11},
    '{4'h2, 5'h0f, 8'h80, 8'hff, 8'h22}, '{4'ha, 5'h0f, 8'h33, 8'hff, 8'h33},
    '{4'h2, 5'h00, 8'h00, 8'h00, 8'h11}, '{4'h2, 5'h00, 8'hff, 8'hff, 8'h11},
    '{4'h2, 5'h00, 8'h14, 8'h00, 8'h11}, '{4'h7, 5'h04, 8'h30, 8'h00, 8'h00}};

  vf_induction_motor_drive #(.TICK_CYCLES(TC)) dut (
    .clk_sys(clk_sys), .rst(rst), .switch_rate_select(switch_rate_select),
    .cfg_wr(cfg_wr), .cfg_sel(cfg_sel), .cfg_index(cfg_index),
    .cfg_data(cfg_data), .flag_clear_request(flag_clear_request),
    .param_rd_index(param_rd_index), .param_rd_value(param_rd_value),
    .cmd_status(cmd_status), .tick_flag(tick_flag),
    .actual_freq(actual_freq), .modulation(modulation), .running(running),
    .kick_active(kick_active), .drive_output_a(drive_output_a),
    .drive_output_b(drive_output_b));
  power_stage_model stage (.clk_sys(clk_sys), .restart(restart),
    .leg_a(drive_output_a), .leg_b(drive_output_b), .min_gap(min_gap));

  // ----------------------------------------------------------------------
  // clock, watchdog and shared tasks
  // ----------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (90000) @(posedge clk_sys);
    mismatches++;
    test_done();
  end
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #5;
  endtask
  task automatic wr(input logic [3:0] s, input logic [7:0] d,
      input logic [4:0] i = 5'h00);
    step(1);
    {cfg_wr, cfg_sel, cfg_index, cfg_data} = {1'b1, s, i, d};
    step(1);
    cfg_wr = 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_freq;
    logic [7:0] old;
    old = actual_freq;
    n = 0;
    while (actual_freq === old && n < 40 * TC) begin
      step(1);
      n++;
    end
  endtask
  task automatic wait_tick;
    n = 0;
    while (tick_flag !== 1'b1 && n < 3 * TC) begin
      step(1);
      n++;
    end
  endtask
  task automatic period(input logic r, input int k, input logic [15:0] p);
    switch_rate_select = r;
    restart = 1'b1;
    step(1);
    restart = 1'b0;
    step(k);
    chk("pwm period", min_gap, p);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    {rst, switch_rate_select, cfg_wr, flag_clear_request, restart} = 5'h10;
    {cfg_sel, cfg_index, cfg_data, param_rd_index} = '0;
    step(4);
    rst = 1'b0;
    chk("reset outputs", {cmd_status, actual_freq, modulation, running,
      kick_active, tick_flag, drive_output_a, drive_output_b}, 0);
    $display("test reset done");
    foreach (rows[k]) begin
      wr(rows[k].sel, rows[k].data, rows[k].idx);
      param_rd_index = rows[k].idx[3:0];
      step(2);
      chk("status", cmd_status, rows[k].st);
      chk("param", param_rd_value, rows[k].prm);
    end
    $display("test table done");
    wait_tick();
    flag_clear_request = 1'b1;
    step(1);
    flag_clear_request = 1'b0;
    chk("tick clear", tick_flag, 0);
    wait_tick();
    chk("tick spacing", n, TC - 1);
    flag_clear_request = 1'b1;
    step(1);
    flag_clear_request = 1'b0;
    $display("test tick done");
    wr(4'h8, 8'd100);
    wr(4'h9, 8'd100);
    wr(4'h6, 8'd24);
    step(2);
    chk("plain start", {running, kick_active, actual_freq}, 10'h200);
    wait_freq();
    chk("accel 1", actual_freq, 8'd10);
    wait_freq();
    chk("accel 2", actual_freq, 8'd20);
    wait_freq();
    chk("accel clamp", actual_freq, 8'd24);
    step(2 * TC);
    chk("curve mod", modulation, 8'd36);
    wr(4'h7, 8'd60, 5'd3);
    wr(4'h9, 8'd150);
    step(2 * TC);
    chk("comp mod", modulation, 8'd90);
    wr(4'h7, 8'hff, 5'd3);
    step(2 * TC);
    chk("saturated mod", modulation, 8'hc8);
    wr(4'h7, 8'd60, 5'd3);
    wr(4'h9, 8'd100);
    period(1'b0, 20000, 16'd2051);
    period(1'b1, 10000, 16'd1024);
    $display("test run done");
    wr(4'h6, 8'd9);
    wait_freq();
    chk("decel 1", actual_freq, 8'd19);
    wait_freq();
    chk("decel 2", actual_freq, 8'd14);
    wait_freq();
    chk("decel clamp", actual_freq, 8'd9);
    wr(4'h6, 8'd0);
    step(2);
    chk("stop", {running, actual_freq}, 0);
    step(2100);
    chk("legs idle", {drive_output_a, drive_output_b}, 0);
    $display("test stop done");
    wr(4'h5, 8'd1);
    wr(4'h4, 8'd50);
    wr(4'h3, 8'd10);
    wr(4'hb, 8'h00);
    wr(4'h6, 8'd30);
    step(2);
    chk("kick start", {running, kick_active, actual_freq, modulation},
      18'h3140a);
    n = 0;
    while (kick_active === 1'b1 && n < 20 * TC) begin
      step(1);
      n++;
    end
    chk("kick length", n >= 15 * TC && n <= 16 * TC + 4, 1);
    wr(4'h6, 8'd0);
    step(2);
    $display("test kick done");
    test_done();
  end
endmodule // testbench
`default_nettype wire
